/* hdl/cre_engine.sv */
/*
 * Cable reflectometry engine: control/window/threshold registers, pulse
 * launch, windowed peak and threshold monitor with 8 ns time stamps.
 * Assumes the converter samples arrive on clk_sys, one per cycle, and that
 * the register port is driven synchronously by the management logic with
 * the diagnostics page already selected.
 */
// Operation
// - Enable bit hands both drivers to engine
// - Send bit launches pulse and starts monitor
// - Bit 14 picks slow or fast driver
// - Slow driver sends 50 or 100 ns
// - Fast driver width 8 ns steps, 56 max
// - Fast pulses alternate positive then negative
// - Width field bits 10:8, zero to seven
// - Width zero sends nothing, monitor still runs
// - Bit 13 sends pulse on receive pair
// - Bit 12 monitors receive pair
// - Bit 7 tracks negative instead of positive
// - Monitor finds peak and threshold crossing
// - First peak and crossing times in 8 ns
// - Timer starts when the pulse goes out
// - Window start bits 15:8, stop 7:0
// - Window defaults 0 to 255, 8 ns steps
// - Peak and threshold results are readable
`timescale 1ns/1ns
`default_nettype none
module cre_engine
    import cre_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic diag_page_sel,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rdata,
    // Converter samples
    input wire logic [7:0] adc_tx_sample,
    input wire logic [7:0] adc_rx_sample,
    // Line driver control
    output logic drv_takeover,
    output logic pulse_on_rx_pair,
    output logic slow_line_driver_pulse,
    output logic fast_line_driver_pos,
    output logic fast_line_driver_neg,
    output logic busy
);
    // ==================================================================
    // State
    typedef enum logic [1:0] {
        CRE_IDLE = 2'b01,
        CRE_RUN = 2'b10
    } cre_state_e;

    cre_state_e state_q;
    logic [15:0] ctrl_q;
    logic [15:0] win_q;
    logic [7:0] thresh_q;
    logic [7:0] timer_q;
    logic phase_q;
    logic [7:0] peak_val_q;
    logic [7:0] peak_time_q;
    logic [7:0] thr_val_q;
    logic [7:0] thr_time_q;
    logic thr_hit_q;
    logic launch;
    logic sample_now;
    logic in_window;
    logic last_step;
    logic [7:0] raw;
    logic signed [7:0] level;

    // Polarity-adjusted level: min mode negates, saturating -128 to +127
    function automatic logic signed [7:0] polar(input logic [7:0] s, input logic neg);
        logic signed [7:0] r;
        r = $signed(s);
        if (neg) begin
            r = (s == 8'h80) ? 8'sh7F : -$signed(s);
        end
        return r;
    endfunction : polar

    function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] ofs);
        return diag_page_sel && (a == ofs);
    endfunction : reg_hit

    // ==================================================================
    // Decode
    assign launch = ce && state_q == CRE_IDLE && ctrl_q[CTL_EN] && ctrl_q[CTL_SEND];
    assign sample_now = state_q == CRE_RUN && phase_q;
    assign in_window = (timer_q >= win_q[15:8]) && (timer_q <= win_q[7:0]);
    assign last_step = sample_now && (timer_q == win_q[7:0] || timer_q == 8'hFF);
    assign raw = ctrl_q[CTL_MON_RX] ? adc_rx_sample : adc_tx_sample;
    assign level = polar(raw, ctrl_q[CTL_MIN]);

    // ==================================================================
    // Control register; end-of-run clear of send outranks a register write of the send bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else if (ce) begin
            if (reg_wr_en && reg_hit(reg_addr, OFS_CTRL)) begin
                ctrl_q <= reg_wdata;
                // A run in flight cannot be cancelled by rewriting the send bit
                if (state_q == CRE_RUN && !last_step) begin
                    ctrl_q[CTL_SEND] <= 1'b1;
                end else if (last_step) begin
                    ctrl_q[CTL_SEND] <= 1'b0;
                end
            end else if (last_step) begin
                ctrl_q[CTL_SEND] <= 1'b0;
            end else if (!ctrl_q[CTL_EN]) begin
                ctrl_q[CTL_SEND] <= 1'b0;
            end
        end
    end

    // Window and threshold registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            win_q <= WIN_RST;
            thresh_q <= THRESH_RST;
        end else if (ce && reg_wr_en) begin
            if (reg_hit(reg_addr, OFS_WIN)) begin
                win_q <= reg_wdata;
            end
            if (reg_hit(reg_addr, OFS_THRESH)) begin
                thresh_q <= reg_wdata[7:0];
            end
        end
    end

    // ==================================================================
    // Sequencer and 8 ns timer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= CRE_IDLE;
            timer_q <= 8'h00;
            phase_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                CRE_IDLE: begin
                    if (launch) begin
                        state_q <= CRE_RUN;
                        timer_q <= 8'h00;
                        phase_q <= 1'b0;
                    end
                end
                CRE_RUN: begin
                    phase_q <= ~phase_q;
                    if (last_step) begin
                        state_q <= CRE_IDLE;
                    end else if (phase_q) begin
                        timer_q <= timer_q + 8'h01;
                    end
                    if (!ctrl_q[CTL_EN]) begin
                        state_q <= CRE_IDLE;
                    end
                end
                default: begin
                    state_q <= CRE_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Peak monitor; strict compare keeps the first occurrence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            peak_val_q <= 8'h00;
            peak_time_q <= 8'h00;
        end else if (ce) begin
            if (launch) begin
                peak_val_q <= 8'h80;
                peak_time_q <= 8'h00;
            end else if (sample_now && in_window && level > $signed(peak_val_q)) begin
                peak_val_q <= level;
                peak_time_q <= timer_q;
            end
        end
    end

    // Threshold monitor
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            thr_val_q <= 8'h00;
            thr_time_q <= 8'h00;
            thr_hit_q <= 1'b0;
        end else if (ce) begin
            if (launch) begin
                thr_val_q <= 8'h00;
                thr_time_q <= 8'h00;
                thr_hit_q <= 1'b0;
            end else if (sample_now && in_window && !thr_hit_q
                         && level > $signed(thresh_q)) begin
                thr_hit_q <= 1'b1;
                thr_val_q <= level;
                thr_time_q <= timer_q;
            end
        end
    end

    // ==================================================================
    // Read data; unmapped offsets read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce && reg_rd_en) begin
            if (reg_hit(reg_addr, OFS_CTRL)) begin
                reg_rdata <= ctrl_q;
            end else if (reg_hit(reg_addr, OFS_WIN)) begin
                reg_rdata <= win_q;
            end else if (reg_hit(reg_addr, OFS_PEAK)) begin
                reg_rdata <= {peak_val_q, peak_time_q};
            end else if (reg_hit(reg_addr, OFS_THR)) begin
                reg_rdata <= {thr_val_q, thr_time_q};
            end else if (reg_hit(reg_addr, OFS_THRESH)) begin
                reg_rdata <= {8'h00, thresh_q};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ==================================================================
    // Driver outputs
    assign drv_takeover = ctrl_q[CTL_EN];
    assign pulse_on_rx_pair = ctrl_q[CTL_TX_RX];
    assign busy = state_q == CRE_RUN;

    cre_pulse_gen u_pulse (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .start(launch),
        .fast_mode(ctrl_q[CTL_FAST]),
        .width(ctrl_q[CTL_WID_HI:CTL_WID_LO]),
        .slow_pulse(slow_line_driver_pulse),
        .fast_pos(fast_line_driver_pos),
        .fast_neg(fast_line_driver_neg)
    );

    // ==================================================================
    // Checks
    sequence s_launch;
        launch;
    endsequence
    sequence s_zero_launch;
        launch && ctrl_q[CTL_WID_HI:CTL_WID_LO] == 3'h0;
    endsequence

    property p_takeover;
        @(posedge clk_sys) disable iff (rst || !ce)
        (reg_wr_en && reg_hit(reg_addr, OFS_CTRL) && reg_wdata[CTL_EN]) |=> drv_takeover;
    endproperty
    a_takeover: assert property (p_takeover) else $error("enable did not take drivers");

    property p_start;
        @(posedge clk_sys) disable iff (rst || !ce)
        s_launch |=> busy && timer_q == 8'h00 ##2 timer_q == 8'h01;
    endproperty
    a_start: assert property (p_start) else $error("launch did not start timer");

    property p_zero_width;
        @(posedge clk_sys) disable iff (rst || !ce)
        s_zero_launch |=> (busy && !slow_line_driver_pulse && !fast_line_driver_pos
                           && !fast_line_driver_neg) [*4];
    endproperty
    a_zero_width: assert property (p_zero_width) else $error("zero width pulse sent");

    property p_fast_sel;
        @(posedge clk_sys) disable iff (rst || !ce)
        (launch && !ctrl_q[CTL_FAST] && ctrl_q[CTL_WID_HI:CTL_WID_LO] != 3'h0)
            |=> slow_line_driver_pulse && !fast_line_driver_pos && !fast_line_driver_neg;
    endproperty
    a_fast_sel: assert property (p_fast_sel) else $error("wrong driver used");

    property p_send_clear;
        @(posedge clk_sys) disable iff (rst || !ce)
        last_step |=> !ctrl_q[CTL_SEND] && !busy;
    endproperty
    a_send_clear: assert property (p_send_clear) else $error("send bit not cleared");

    property p_hold;
        @(posedge clk_sys) disable iff (rst || !ce)
        (!busy && !launch) |=> $stable(peak_val_q) && $stable(thr_time_q);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed while idle");

    property p_window;
        @(posedge clk_sys) disable iff (rst || !ce)
        (sample_now && !in_window) |=> $stable(peak_time_q) && $stable(thr_hit_q);
    endproperty
    a_window: assert property (p_window) else $error("sample outside window used");

    property p_thr_first;
        @(posedge clk_sys) disable iff (rst || !ce)
        (thr_hit_q && !launch) |=> $stable(thr_time_q);
    endproperty
    a_thr_first: assert property (p_thr_first) else $error("threshold time overwritten");

    property p_peak_track;
        @(posedge clk_sys) disable iff (rst || !ce)
        (sample_now && in_window && level > $signed(peak_val_q) && !launch)
            |=> peak_time_q == $past(timer_q);
    endproperty
    a_peak_track: assert property (p_peak_track) else $error("peak time not recorded");
endmodule : cre_engine
`default_nettype wire

/* hdl/cre_pkg.sv */
/*
 * Constants shared by the cable reflectometry engine: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 250 MHz system clock.
 */
package cre_pkg;
    // ==================================================================
    // Register offsets (diagnostics page)
    localparam logic [4:0] OFS_CTRL = 5'h16;
    localparam logic [4:0] OFS_WIN = 5'h17;
    localparam logic [4:0] OFS_PEAK = 5'h18;
    localparam logic [4:0] OFS_THR = 5'h19;
    localparam logic [4:0] OFS_THRESH = 5'h1C;

    // ==================================================================
    // Control field positions
    localparam int CTL_EN = 15;
    localparam int CTL_FAST = 14;
    localparam int CTL_TX_RX = 13;
    localparam int CTL_MON_RX = 12;
    localparam int CTL_SEND = 11;
    localparam int CTL_WID_HI = 10;
    localparam int CTL_WID_LO = 8;
    localparam int CTL_MIN = 7;

    // ==================================================================
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] WIN_RST = 16'h00FF;
    localparam logic [7:0] THRESH_RST = 8'h40;

    // ==================================================================
    // Timing
    localparam int CLK_PS = 4000;
    localparam int STEP_NS = 8;
    localparam int STEP_CYC = (STEP_NS * 1000) / CLK_PS;
    localparam int LINK_SHORT_NS = 50;
    localparam int LINK_LONG_NS = 100;
    localparam int LINK_SHORT_CYC = (LINK_SHORT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int LINK_LONG_CYC = (LINK_LONG_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [2:0] LINK_LONG_MIN_WID = 3'h4;
endpackage : cre_pkg

/* hdl/cre_pulse_gen.sv */
/*
 * Test pulse generator driving the slow or fast line driver.
 * Assumes start is a one-cycle strobe and the caller holds settings stable.
 */
`timescale 1ns/1ns
`default_nettype none
module cre_pulse_gen
    import cre_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic fast_mode,
    input wire logic [2:0] width,
    // Driver outputs
    output logic slow_pulse,
    output logic fast_pos,
    output logic fast_neg
);
    // ==================================================================
    // Length in clock cycles
    function automatic logic [5:0] pulse_len(input logic fast, input logic [2:0] w);
        logic [5:0] n;
        n = 6'h00;
        if (w == 3'h0) begin
            n = 6'h00;
        end else if (fast) begin
            n = 6'(int'(w) * STEP_CYC);
        end else if (w < LINK_LONG_MIN_WID) begin
            n = 6'(LINK_SHORT_CYC);
        end else begin
            n = 6'(LINK_LONG_CYC);
        end
        return n;
    endfunction : pulse_len

    logic [5:0] cnt_q;
    logic fast_q;
    logic neg_q;

    // ==================================================================
    // Pulse counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 6'h00;
            fast_q <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_q <= pulse_len(fast_mode, width);
                fast_q <= fast_mode;
            end else if (cnt_q != 6'h00) begin
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end

    // Polarity flips on each fast pulse actually sent
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            neg_q <= 1'b0;
        end else if (ce && start && fast_mode && width != 3'h0) begin
            neg_q <= ~neg_q;
        end
    end

    // neg_q already flipped at start, so the active pulse uses its inverse
    assign slow_pulse = (cnt_q != 6'h00) && !fast_q;
    assign fast_pos = (cnt_q != 6'h00) && fast_q && neg_q;
    assign fast_neg = (cnt_q != 6'h00) && fast_q && !neg_q;

    // ==================================================================
    // Checks
    // Polarity of the last fast pulse seen on the pins, for the check below
    logic last_pos_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_pos_q <= 1'b0;
        end else if (ce && (fast_pos || fast_neg)) begin
            last_pos_q <= fast_pos;
        end
    end

    sequence s_short_start;
        start && ce && !fast_mode && width != 3'h0 && width < LINK_LONG_MIN_WID;
    endsequence
    sequence s_fast_start;
        start && ce && fast_mode && width != 3'h0;
    endsequence
    property p_slow_short;
        @(posedge clk_sys) disable iff (rst || !ce)
        s_short_start |=> slow_pulse [*7] ##6 slow_pulse ##1 !slow_pulse;
    endproperty
    a_slow_short: assert property (p_slow_short) else $error("link pulse not 50 ns");

    property p_fast_width;
        @(posedge clk_sys) disable iff (rst || !ce)
        (start && fast_mode && width == 3'h7) |=> (fast_pos || fast_neg) [*7]
            ##7 (fast_pos || fast_neg) ##1 !(fast_pos || fast_neg);
    endproperty
    a_fast_width: assert property (p_fast_width) else $error("fast pulse width wrong");

    property p_alternate;
        @(posedge clk_sys) disable iff (rst || !ce)
        s_fast_start |=> (fast_pos != fast_neg) && (fast_neg == last_pos_q);
    endproperty
    a_alternate: assert property (p_alternate) else $error("fast polarity not alternating");
endmodule : cre_pulse_gen
`default_nettype wire

/* tb/cre_cable_model.sv */
/*
 * Cable and analog front end model: every outgoing pulse shows on the
 * driven pair while it lasts and comes back as one echo after a fixed delay.
 * Assumes the driver outputs change on clk_sys and samples are taken on it.
 */
`timescale 1ns/1ns
`default_nettype none
module cre_cable_model #(
    parameter int ECHO_DLY = 40,
    parameter logic [7:0] ECHO_AMP = 8'h30,
    parameter logic [7:0] OUT_AMP = 8'h60,
    parameter logic [7:0] BASE = 8'h02
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Line drivers
    input wire logic pulse_on_rx_pair,
    input wire logic slow_line_driver_pulse,
    input wire logic fast_line_driver_pos,
    input wire logic fast_line_driver_neg,
    // Converter samples
    output logic [7:0] adc_tx_sample,
    output logic [7:0] adc_rx_sample
);
    logic drv, drv_q, neg_q, rx_q, echo, sel_rx, neg;
    logic [9:0] cnt_q;
    logic [7:0] amp, line;

    // ==================================================================
    // Line levels
    assign drv = slow_line_driver_pulse | fast_line_driver_pos | fast_line_driver_neg;
    // Echo lasts two whole 8 ns steps, so either sampling phase sees it
    assign echo = (cnt_q >= 10'(ECHO_DLY)) && (cnt_q < 10'(ECHO_DLY + 4));
    assign amp = drv ? OUT_AMP : ECHO_AMP;
    assign neg = drv ? fast_line_driver_neg : neg_q;
    assign line = (drv || echo) ? (neg ? 8'(-amp) : amp) : BASE;
    assign sel_rx = drv ? pulse_on_rx_pair : rx_q;
    assign adc_rx_sample = sel_rx ? line : BASE;
    assign adc_tx_sample = sel_rx ? BASE : line;

    // ==================================================================
    // Time since the last pulse began
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drv_q <= 1'b0;
            neg_q <= 1'b0;
            rx_q <= 1'b0;
            cnt_q <= 10'h3FF;
        end else begin
            drv_q <= drv;
            if (drv && !drv_q) begin
                cnt_q <= 10'h001;
                neg_q <= fast_line_driver_neg;
                rx_q <= pulse_on_rx_pair;
            end else if (cnt_q != 10'h3FF) begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end
endmodule : cre_cable_model
`default_nettype wire

/* tb/cre_engine_bench.sv */
/*
 * Self-checking bench of the reflectometry engine with a cable model.
 * Assumes the echo of the model arrives 40 cycles (step 20) after a pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module cre_engine_bench
    import cre_pkg::*;
();
    logic clk_sys, rst, ce, diag_page_sel, reg_wr_en, reg_rd_en;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0] adc_tx_sample, adc_rx_sample;
    logic drv_takeover, pulse_on_rx_pair, slow_p, pos_p, neg_p, busy;
    int num_errors, comparisons;

    // ==================================================================
    // Design and cable
    cre_engine dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .diag_page_sel(diag_page_sel),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .adc_tx_sample(adc_tx_sample),
        .adc_rx_sample(adc_rx_sample), .drv_takeover(drv_takeover),
        .pulse_on_rx_pair(pulse_on_rx_pair), .slow_line_driver_pulse(slow_p),
        .fast_line_driver_pos(pos_p), .fast_line_driver_neg(neg_p), .busy(busy));
    cre_cable_model cable (.clk_sys(clk_sys), .rst(rst), .pulse_on_rx_pair(pulse_on_rx_pair),
        .slow_line_driver_pulse(slow_p), .fast_line_driver_pos(pos_p),
        .fast_line_driver_neg(neg_p), .adc_tx_sample(adc_tx_sample),
        .adc_rx_sample(adc_rx_sample));

    // ==================================================================
    // Helpers
    task automatic chk_reg(input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_reg

    task automatic chk_cnt(input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_cnt

    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd

    // One measurement: pulse cycles per driver, send bit, both results
    task automatic run(input logic [15:0] ctrl, input int es, input int ep, input int en,
            input logic [15:0] epk, input logic [15:0] eth);
        int ns, np, nn, i;
        logic seen;
        logic [15:0] v;
        ns = 0;
        np = 0;
        nn = 0;
        seen = 1'b0;
        wr(OFS_CTRL, ctrl);
        for (i = 0; i < 2000; i++) begin
            @(posedge clk_sys);
            #1;
            ns += int'(slow_p === 1'b1);
            np += int'(pos_p === 1'b1);
            nn += int'(neg_p === 1'b1);
            if (busy === 1'b1) begin
                seen = 1'b1;
            end else if (seen) begin
                break;
            end
        end
        if (i == 2000) begin
            num_errors++;
            finish_test();
        end else begin
            chk_cnt(es, ns);
            chk_cnt(ep, np);
            chk_cnt(en, nn);
            rd(OFS_CTRL, v);
            chk_reg(ctrl & 16'hF7FF, v);
            rd(OFS_PEAK, v);
            chk_reg(epk, v);
            rd(OFS_THR, v);
            chk_reg(eth, v);
        end
    endtask : run

    // ==================================================================
    // Scenarios
    task automatic t_regs;
        logic [15:0] v;
        rd(OFS_CTRL, v);
        chk_reg(CTRL_RST, v);
        rd(OFS_WIN, v);
        chk_reg(16'h00FF, v);
        rd(OFS_THRESH, v);
        chk_reg(16'h0040, v);
        rd(5'h1F, v);
        chk_reg(16'h0000, v);
        diag_page_sel = 1'b0;
        rd(OFS_WIN, v);
        chk_reg(16'h0000, v);
        diag_page_sel = 1'b1;
        wr(OFS_THRESH, 16'h0020);
        rd(OFS_THRESH, v);
        chk_reg(16'h0020, v);
        wr(OFS_WIN, 16'h1030);
    endtask : t_regs

    task automatic t_takeover;
        wr(OFS_CTRL, 16'hA000);
        chk_reg(16'h0001, 16'(drv_takeover));
        chk_reg(16'h0001, 16'(pulse_on_rx_pair));
        // Clock enable low: a write must not reach the control register
        ce = 1'b0;
        wr(OFS_CTRL, 16'h0000);
        chk_reg(16'h0001, 16'(drv_takeover));
        ce = 1'b1;
    endtask : t_takeover

    task automatic t_fast;
        run(16'hC900, 0, 2, 0, 16'h3014, 16'h3014);
        run(16'hCF80, 0, 0, 14, 16'h3014, 16'h3014);
    endtask : t_fast

    task automatic t_slow;
        run(16'h8A00, LINK_SHORT_CYC, 0, 0, 16'h3014, 16'h3014);
        run(16'h8D00, LINK_LONG_CYC, 0, 0, 16'h3014, 16'h3014);
    endtask : t_slow

    task automatic t_baseline;
        run(16'hC800, 0, 0, 0, 16'h0210, 16'h0000);
    endtask : t_baseline

    task automatic t_pairs;
        run(16'hF900, 0, 2, 0, 16'h3014, 16'h3014);
        run(16'hE900, 0, 0, 2, 16'h0210, 16'h0000);
    endtask : t_pairs

    task automatic t_window;
        wr(OFS_WIN, 16'h0205);
        run(16'hC900, 0, 2, 0, 16'h0202, 16'h0000);
    endtask : t_window

    // ==================================================================
    // Clock, reset and sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        num_errors = 0;
        comparisons = 0;
        rst = 1'b1;
        ce = 1'b1;
        diag_page_sel = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_regs();
        t_takeover();
        t_fast();
        t_slow();
        t_baseline();
        t_pairs();
        t_window();
        finish_test();
    end
endmodule : cre_engine_bench
`default_nettype wire
